// [bfp_map.vh]
// Register map, field positions, reset values and timing for the breaker failure protection block
`ifndef BFP_MAP_VH
`define BFP_MAP_VH

// --------------------------------------------------------------
// Register offsets
// --------------------------------------------------------------
`define BFP_CTRL        8'h00
`define BFP_RT_DELAY    8'h04
`define BFP_BF_DELAY    8'h08
`define BFP_EV_MASK     8'h0C
`define BFP_STATUS      8'h10
`define BFP_CNT_RT      8'h14
`define BFP_CNT_BF      8'h18
`define BFP_CNT_ST      8'h1C
`define BFP_CNT_BLK     8'h20
`define BFP_LOG_SEL     8'h24
`define BFP_LOG_TIME    8'h28
`define BFP_LOG_EVT     8'h2C
`define BFP_LOG_CUR     8'h30
`define BFP_LOG_TTR     8'h34
`define BFP_LOG_TTB     8'h38

// --------------------------------------------------------------
// Control fields and modes
// --------------------------------------------------------------
`define BFP_CTRL_MODE_LSB  0
`define BFP_CTRL_RT_EN     4
`define BFP_CTRL_PH_EN     5
`define BFP_CTRL_RES_EN    6
`define BFP_CTRL_RST       32'h00000070
`define BFP_MODE_CUR       2'h0
`define BFP_MODE_CUR_AND   2'h1
`define BFP_MODE_CUR_OR    2'h2
`define BFP_MODE_SIG       2'h3
`define BFP_EV_MASK_RST    16'hFFFF

// --------------------------------------------------------------
// Event indices
// --------------------------------------------------------------
`define BFP_EV_START    3'h0
`define BFP_EV_RETRIP   3'h1
`define BFP_EV_BF       3'h2
`define BFP_EV_BLOCK    3'h3
`define BFP_EV_MON      3'h4
`define BFP_EV_SIG      3'h5
`define BFP_EV_PHASE    3'h6
`define BFP_EV_RES      3'h7

// --------------------------------------------------------------
// Timing
// --------------------------------------------------------------
`define BFP_CLK_NS      100
`define BFP_TICK_NS     5000000
`define BFP_STEP_MS     5
`define BFP_RT_DLY_MS   100
`define BFP_BF_DLY_MS   200
`define BFP_LOG_DEPTH   12

`endif

// [bfp_delay_timer.v]
// Tick-driven delay timer with clear and remaining-time output
module bfp_delay_timer
#(
   parameter W = 19
)
(
   input  wire         ref_clk_i,
   input  wire         rst_n_i,
   input  wire         tick_i,
   input  wire         run_i,
   input  wire         clear_i,
   input  wire [W-1:0] limit_i,
   output wire         done_o,
   output wire [W-1:0] remain_o
);

   reg [W-1:0] count_q;

   // ------------------------------------------------------------
   // Counter
   // ------------------------------------------------------------
   always @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
         count_q <= {W{1'b0}};
      else if (tick_i)
      begin
         if (clear_i)
            count_q <= {W{1'b0}};
         else if (run_i && (count_q < limit_i))
            count_q <= count_q + {{(W-1){1'b0}}, 1'b1};
      end
   end

   assign done_o   = (count_q >= limit_i);
   assign remain_o = done_o ? {W{1'b0}} : (limit_i - count_q);

endmodule // bfp_delay_timer

// [bfp_log_mem.v]
// Operation log storage with registered read data
module bfp_log_mem
#(
   parameter W     = 111,
   parameter DEPTH = 12,
   parameter AW    = 4
)
(
   input  wire          ref_clk_i,
   input  wire          wr_en_i,
   input  wire [AW-1:0] wr_addr_i,
   input  wire [W-1:0]  wr_data_i,
   input  wire [AW-1:0] rd_addr_i,
   output reg  [W-1:0]  rd_data_o
);

   reg [W-1:0] mem [0:DEPTH-1];

   // ------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------
   // No reset on the array: contents are qualified by the record count
   always @(posedge ref_clk_i)
   begin
      if (wr_en_i)
         mem[wr_addr_i] <= wr_data_i;
      rd_data_o <= mem[rd_addr_i];
   end

endmodule // bfp_log_mem

// [bfp_core.v]
// Breaker failure protection core with AHB-Lite register slave
//
// The implementer's own choices: the AHB-Lite register port and the placing of the registers.
`include "bfp_map.vh"
module bfp_core
#(
   parameter TICK_CYCLES = `BFP_TICK_NS / `BFP_CLK_NS,
   parameter DLY_W       = 19,
   parameter CUR_W       = 16,
   parameter CNT_W       = 16
)
(
   input  wire             ref_clk_i,
   input  wire             rst_n_i,
   input  wire             hsel_i,
   input  wire [7:0]       haddr_i,
   input  wire [1:0]       htrans_i,
   input  wire             hwrite_i,
   input  wire [2:0]       hsize_i,
   input  wire [31:0]      hwdata_i,
   input  wire             hready_i,
   output reg  [31:0]      hrdata_o,
   output wire             hreadyout_o,
   output wire             hresp_o,
   input  wire             phase_over_i,
   input  wire             residual_over_i,
   input  wire             trip_monitor_i,
   input  wire             signal_input_i,
   input  wire             block_i,
   input  wire [CUR_W-1:0] phase_max_i,
   input  wire [CUR_W-1:0] residual_i,
   input  wire [2:0]       setting_group_i,
   input  wire [31:0]      time_ms_i,
   output reg              start_o,
   output reg              blocked_o,
   output reg              redundant_trip_o,
   output reg              breaker_failure_output_o,
   output reg              event_valid_o,
   output reg  [2:0]       event_id_o,
   output reg              event_on_o,
   output reg  [31:0]      event_stamp_o
);

   localparam LOG_W = 32 + 4 + 2 * CUR_W + 2 * DLY_W + 3;
   localparam [31:0] LOG_DEPTH_M1 = `BFP_LOG_DEPTH - 1;
   localparam [3:0]  LOG_LAST     = LOG_DEPTH_M1[3:0];
   localparam [31:0] CTRL_RST     = `BFP_CTRL_RST;
   localparam [31:0] RT_RST       = `BFP_RT_DLY_MS / `BFP_STEP_MS;
   localparam [31:0] BF_RST       = `BFP_BF_DLY_MS / `BFP_STEP_MS;

   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   reg  [4:0] sync1_q;
   reg  [4:0] sync2_q;
   always @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
      begin
         sync1_q <= 5'h00;
         sync2_q <= 5'h00;
      end
      else
      begin
         sync1_q <= {block_i, signal_input_i, trip_monitor_i, residual_over_i, phase_over_i};
         sync2_q <= sync1_q;
      end
   end

   // ------------------------------------------------------------
   // Program-cycle tick
   // ------------------------------------------------------------
   reg  [31:0] tick_cnt_q;
   wire        tick = (tick_cnt_q == TICK_CYCLES - 1);
   always @(posedge ref_clk_i)
   begin
      if (!rst_n_i || tick)
         tick_cnt_q <= 32'h00000000;
      else
         tick_cnt_q <= tick_cnt_q + 32'h00000001;
   end

   // ------------------------------------------------------------
   // Settings
   // ------------------------------------------------------------
   reg  [6:0]       ctrl_q;
   reg  [DLY_W-1:0] rt_dly_q;
   reg  [DLY_W-1:0] bf_dly_q;
   reg  [15:0]      ev_mask_q;
   reg  [3:0]       log_sel_q;
   wire [1:0]       mode   = ctrl_q[`BFP_CTRL_MODE_LSB +: 2];
   wire             rt_en  = ctrl_q[`BFP_CTRL_RT_EN];

   // ------------------------------------------------------------
   // Pick-up evaluation, once per tick
   // ------------------------------------------------------------
   reg  ph_q;
   reg  res_q;
   reg  mon_q;
   reg  sig_q;
   reg  blk_q;
   always @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
      begin
         ph_q  <= 1'b0;
         res_q <= 1'b0;
         mon_q <= 1'b0;
         sig_q <= 1'b0;
         blk_q <= 1'b0;
      end
      else if (tick)
      begin
         ph_q  <= sync2_q[0] & ctrl_q[`BFP_CTRL_PH_EN];
         res_q <= sync2_q[1] & ctrl_q[`BFP_CTRL_RES_EN];
         mon_q <= sync2_q[2];
         sig_q <= sync2_q[3];
         blk_q <= sync2_q[4];
      end
   end

   wire cur = ph_q | res_q;
   reg  pick;
   reg  run;
   always @*
   begin
      pick = cur;
      run  = cur;
      case (mode)
         `BFP_MODE_CUR:
         begin
            pick = cur;
            run  = cur;
         end
         `BFP_MODE_CUR_AND:
         begin
            pick = cur;
            run  = cur & mon_q;
         end
         `BFP_MODE_CUR_OR:
         begin
            pick = cur | mon_q;
            run  = cur | mon_q;
         end
         default:
         begin
            pick = sig_q;
            run  = sig_q;
         end
      endcase
   end

   // Block wins at pick-up and drops a running start
   wire start_now = pick & ~blk_q;
   wire blk_now   = pick & blk_q;
   wire active    = start_now & run;
   wire rt_done;
   wire bf_done;
   wire [DLY_W-1:0] rt_rem;
   wire [DLY_W-1:0] bf_rem;

   bfp_delay_timer #(.W(DLY_W)) u_rt_timer
   (
      .ref_clk_i (ref_clk_i),
      .rst_n_i   (rst_n_i),
      .tick_i    (tick),
      .run_i     (active),
      .clear_i   (~active | ~rt_en | (mode == `BFP_MODE_SIG)),
      .limit_i   (rt_dly_q),
      .done_o    (rt_done),
      .remain_o  (rt_rem)
   );

   bfp_delay_timer #(.W(DLY_W)) u_bf_timer
   (
      .ref_clk_i (ref_clk_i),
      .rst_n_i   (rst_n_i),
      .tick_i    (tick),
      .run_i     (active),
      .clear_i   (~active),
      .limit_i   (bf_dly_q),
      .done_o    (bf_done),
      .remain_o  (bf_rem)
   );

   always @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
      begin
         start_o                  <= 1'b0;
         blocked_o                <= 1'b0;
         redundant_trip_o         <= 1'b0;
         breaker_failure_output_o <= 1'b0;
      end
      else
      begin
         start_o   <= start_now;
         blocked_o <= blk_now;
         // Done is compared before this tick's step, so output trails count by one cycle
         redundant_trip_o         <= active & rt_en & rt_done & (rt_dly_q != 0 || run);
         breaker_failure_output_o <= active & bf_done;
      end
   end

   // ------------------------------------------------------------
   // Events
   // ------------------------------------------------------------
   wire [7:0] ev_now = {res_q, ph_q, sig_q, mon_q, blocked_o, breaker_failure_output_o,
                        redundant_trip_o, start_o};
   reg  [7:0] ev_prev_q;
   reg  [7:0] on_pend_q;
   reg  [7:0] off_pend_q;
   wire [7:0] on_set  = ev_now & ~ev_prev_q & ev_mask_q[7:0];
   wire [7:0] off_set = ~ev_now & ev_prev_q & ev_mask_q[15:8];
   reg  [7:0] pick_on;
   reg  [7:0] pick_off;
   reg  [2:0] pick_id;
   integer    i;
   always @*
   begin
      pick_on  = 8'h00;
      pick_off = 8'h00;
      pick_id  = 3'h0;
      for (i = 7; i >= 0; i = i - 1)
         if (off_pend_q[i])
         begin
            pick_off = 8'h01 << i;
            pick_id  = i[2:0];
         end
      if (on_pend_q != 8'h00)
      begin
         pick_off = 8'h00;
         for (i = 7; i >= 0; i = i - 1)
            if (on_pend_q[i])
            begin
               pick_on = 8'h01 << i;
               pick_id = i[2:0];
            end
      end
   end

   wire emit_on = (on_pend_q != 8'h00);
   wire emit    = emit_on | (off_pend_q != 8'h00);
   always @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
      begin
         ev_prev_q     <= 8'h00;
         on_pend_q     <= 8'h00;
         off_pend_q    <= 8'h00;
         event_valid_o <= 1'b0;
         event_id_o    <= 3'h0;
         event_on_o    <= 1'b0;
         event_stamp_o <= 32'h00000000;
      end
      else
      begin
         ev_prev_q     <= ev_now;
         // New edges win over the slot being drained this cycle
         on_pend_q     <= (on_pend_q & ~pick_on) | on_set;
         off_pend_q    <= (off_pend_q & ~pick_off) | off_set;
         event_valid_o <= emit;
         event_id_o    <= pick_id;
         event_on_o    <= emit_on;
         event_stamp_o <= time_ms_i;
      end
   end

   // ------------------------------------------------------------
   // Counters
   // ------------------------------------------------------------
   reg  [CNT_W-1:0] cnt_q [0:3];
   reg  [3:0]       cnt_clr;
   wire [3:0]       cnt_inc = {on_set[`BFP_EV_BLOCK] | (ev_now[3] & ~ev_prev_q[3]),
                               ev_now[0] & ~ev_prev_q[0], ev_now[2] & ~ev_prev_q[2],
                               ev_now[1] & ~ev_prev_q[1]};
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1)
      begin : g_cnt
         always @(posedge ref_clk_i)
         begin
            if (!rst_n_i)
               cnt_q[g] <= {CNT_W{1'b0}};
            else if (cnt_clr[g])
               cnt_q[g] <= {{(CNT_W-1){1'b0}}, cnt_inc[g]};
            else if (cnt_inc[g])
               cnt_q[g] <= cnt_q[g] + {{(CNT_W-1){1'b0}}, 1'b1};
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // Operation log
   // ------------------------------------------------------------
   reg  [3:0]       log_head_q;
   reg  [3:0]       log_count_q;
   wire             log_wr = emit_on;
   wire [LOG_W-1:0] log_rec = {time_ms_i, pick_id, 1'b1, phase_max_i, residual_i,
                               rt_rem, bf_rem, setting_group_i};
   wire [4:0]       rd_raw = {1'b0, log_head_q} + 5'h0B - {1'b0, log_sel_q};
   wire [3:0]       rd_slot = (rd_raw >= 5'h0C) ? (rd_raw[3:0] - 4'hC) : rd_raw[3:0];
   wire [LOG_W-1:0] log_rd;

   bfp_log_mem #(.W(LOG_W), .DEPTH(`BFP_LOG_DEPTH), .AW(4)) u_log
   (
      .ref_clk_i (ref_clk_i),
      .wr_en_i   (log_wr),
      .wr_addr_i (log_head_q),
      .wr_data_i (log_rec),
      .rd_addr_i (rd_slot),
      .rd_data_o (log_rd)
   );

   always @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
      begin
         log_head_q  <= 4'h0;
         log_count_q <= 4'h0;
      end
      else if (log_wr)
      begin
         // Head wraps over the oldest record once twelve are held
         log_head_q <= (log_head_q == LOG_LAST) ? 4'h0 : log_head_q + 4'h1;
         if (log_count_q != `BFP_LOG_DEPTH)
            log_count_q <= log_count_q + 4'h1;
      end
   end

   // ------------------------------------------------------------
   // AHB-Lite slave
   // ------------------------------------------------------------
   reg        wr_pend_q;
   reg        rd_pend_q;
   reg  [1:0] rd_wait_q;
   reg  [7:0] addr_q;
   wire       take = hsel_i & hready_i & htrans_i[1];
   // Reads wait two cycles so a log index written just before is reflected
   assign hreadyout_o = ~(rd_pend_q & (rd_wait_q != 2'h0));
   assign hresp_o     = 1'b0;

   reg [31:0] rd_mux;
   always @*
   begin
      rd_mux = 32'h00000000;
      if (addr_q == `BFP_CTRL)
         rd_mux = {25'h0000000, ctrl_q};
      else if (addr_q == `BFP_RT_DELAY)
         rd_mux = {{(32-DLY_W){1'b0}}, rt_dly_q};
      else if (addr_q == `BFP_BF_DELAY)
         rd_mux = {{(32-DLY_W){1'b0}}, bf_dly_q};
      else if (addr_q == `BFP_EV_MASK)
         rd_mux = {16'h0000, ev_mask_q};
      else if (addr_q == `BFP_STATUS)
         rd_mux = {18'h00000, rt_done, bf_done, sig_q, mon_q, res_q, ph_q, blk_q,
                   blocked_o, breaker_failure_output_o, redundant_trip_o, start_o, active, pick, 1'b0};
      else if (addr_q == `BFP_CNT_RT)
         rd_mux = {{(32-CNT_W){1'b0}}, cnt_q[0]};
      else if (addr_q == `BFP_CNT_BF)
         rd_mux = {{(32-CNT_W){1'b0}}, cnt_q[1]};
      else if (addr_q == `BFP_CNT_ST)
         rd_mux = {{(32-CNT_W){1'b0}}, cnt_q[2]};
      else if (addr_q == `BFP_CNT_BLK)
         rd_mux = {{(32-CNT_W){1'b0}}, cnt_q[3]};
      else if (addr_q == `BFP_LOG_SEL)
         rd_mux = {20'h00000, log_count_q, 4'h0, log_sel_q};
      else if (addr_q == `BFP_LOG_TIME)
         rd_mux = log_rd[LOG_W-1 -: 32];
      else if (addr_q == `BFP_LOG_EVT)
         rd_mux = {24'h000000, 1'b0, log_rd[2:0], log_rd[LOG_W-33 -: 4]};
      else if (addr_q == `BFP_LOG_CUR)
         rd_mux = log_rd[LOG_W-37 -: 32];
      else if (addr_q == `BFP_LOG_TTR)
         rd_mux = {{(32-DLY_W){1'b0}}, log_rd[2*DLY_W+2 -: DLY_W]};
      else if (addr_q == `BFP_LOG_TTB)
         rd_mux = {{(32-DLY_W){1'b0}}, log_rd[DLY_W+2 -: DLY_W]};
   end

   always @*
   begin
      cnt_clr = 4'h0;
      if (wr_pend_q)
      begin
         if (addr_q == `BFP_CNT_RT)
            cnt_clr = 4'h1;
         else if (addr_q == `BFP_CNT_BF)
            cnt_clr = 4'h2;
         else if (addr_q == `BFP_CNT_ST)
            cnt_clr = 4'h4;
         else if (addr_q == `BFP_CNT_BLK)
            cnt_clr = 4'h8;
      end
   end

   always @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
      begin
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
         rd_wait_q <= 2'h0;
         addr_q    <= 8'h00;
         hrdata_o  <= 32'h00000000;
         ctrl_q    <= CTRL_RST[6:0];
         rt_dly_q  <= RT_RST[DLY_W-1:0];
         bf_dly_q  <= BF_RST[DLY_W-1:0];
         ev_mask_q <= `BFP_EV_MASK_RST;
         log_sel_q <= 4'h0;
      end
      else
      begin
         if (rd_pend_q && rd_wait_q != 2'h0)
         begin
            rd_wait_q <= rd_wait_q - 2'h1;
            if (rd_wait_q == 2'h1)
               hrdata_o <= rd_mux;
         end
         else
         begin
            wr_pend_q <= take & hwrite_i;
            rd_pend_q <= take & ~hwrite_i;
            rd_wait_q <= (take & ~hwrite_i) ? 2'h2 : 2'h0;
            if (take)
               addr_q <= haddr_i;
         end
         if (wr_pend_q)
         begin
            if (addr_q == `BFP_CTRL)
               ctrl_q <= hwdata_i[6:0];
            else if (addr_q == `BFP_RT_DELAY)
               rt_dly_q <= hwdata_i[DLY_W-1:0];
            else if (addr_q == `BFP_BF_DELAY)
               bf_dly_q <= hwdata_i[DLY_W-1:0];
            else if (addr_q == `BFP_EV_MASK)
               ev_mask_q <= hwdata_i[15:0];
            else if (addr_q == `BFP_LOG_SEL)
               log_sel_q <= (hwdata_i[3:0] > LOG_LAST) ? LOG_LAST : hwdata_i[3:0];
         end
      end
   end

endmodule // bfp_core

// [bfp_assertions.sv]
// Port checks for the breaker failure protection core
module bfp_checker (
   input logic       ref_clk_i,
   input logic       rst_n_i,
   input logic       hsel_i,
   input logic [1:0] htrans_i,
   input logic       hwrite_i,
   input logic       hready_i,
   input logic       hreadyout_o,
   input logic       block_i,
   input logic       start_o,
   input logic       blocked_o,
   input logic       redundant_trip_o,
   input logic       breaker_failure_output_o,
   input logic       event_valid_o,
   input logic [2:0] event_id_o,
   input logic       event_on_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   // ------
   // Checks
   // ------
   start_block_a:
      assert property (!(start_o && blocked_o)) else $error("start and blocked together");
   rt_start_a:
      assert property (redundant_trip_o |-> start_o) else $error("retrip without start");
   bf_start_a:
      assert property (breaker_failure_output_o |-> start_o) else $error("failure output without start");
   // Two sync stages plus one tick bound the reaction to a block
   block_clear_a:
      assert property (block_i [*8] ##1 block_i [*7] |-> !start_o && !redundant_trip_o)
         else $error("start held under block");
   start_pace_a:
      assert property ($changed(start_o) |=> $stable(start_o) [*8]) else $error("start off tick");
   rt_delay_a:
      assert property ($rose(redundant_trip_o) |-> $past(start_o, 8)) else $error("retrip too early");
   start_event_a:
      assert property ($rose(start_o) |-> ##[0:8] (event_valid_o && event_id_o == 3'h0 && event_on_o))
         else $error("start event missing");
   read_wait_a:
      assert property (hsel_i && hready_i && htrans_i[1] && !hwrite_i |=> !hreadyout_o [*2] ##1 hreadyout_o)
         else $error("read wait wrong");
endmodule // bfp_checker

bind bfp_core bfp_checker u_chk (.ref_clk_i, .rst_n_i, .hsel_i, .htrans_i, .hwrite_i, .hready_i,
   .hreadyout_o, .block_i, .start_o, .blocked_o, .redundant_trip_o, .breaker_failure_output_o,
   .event_valid_o, .event_id_o, .event_on_o);

// [bfp_partner.sv]
// Primary protection stage, breaker and trip coils facing the block
module bfp_partner (
   input  wire logic clk_i,
   input  wire logic fault_i,
   input  wire logic trip_en_i,
   input  wire logic stuck_i,
   input  wire logic slow_i,
   input  wire logic retrip_i,
   output logic      current_o,
   output logic      trip_mon_o
);
   timeunit 1ns;
   timeprecision 1ns;
   int   age_q = 0;
   logic open_q = 1'b0;
   initial trip_mon_o = 1'b0;
   // ------
   // Breaker
   // ------
   always @(posedge clk_i)
   begin
      age_q <= fault_i ? age_q + 1 : 0;
      // Slow primary trip shows the timers held back
      trip_mon_o <= fault_i && trip_en_i && age_q > (slow_i ? 40 : 3);
      // A stuck breaker ignores both coils
      open_q <= fault_i && (open_q || ((trip_mon_o || retrip_i) && !stuck_i));
   end
   assign current_o = fault_i && !open_q;
endmodule // bfp_partner

// [bfp_tb.sv]
// Self-checking testbench for the breaker failure protection core
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   // ------
   // Signals
   // ------
   logic        ref_clk_i = 1'b0, rst_n_i = 1'b0, hsel_i = 1'b0, hwrite_i = 1'b0;
   logic [7:0]  haddr_i = 8'h00;
   logic [1:0]  htrans_i = 2'h0;
   logic [31:0] hwdata_i = 32'h0, time_ms_i = 32'h0, rd;
   logic        residual_over_i = 1'b0, signal_input_i = 1'b0, block_i = 1'b0;
   logic        fault = 1'b0, trip_en = 1'b0, stuck = 1'b0, slow = 1'b0;
   wire  [31:0] hrdata_o, event_stamp_o;
   wire  [2:0]  event_id_o;
   wire         hreadyout_o, hresp_o, phase_over_i, trip_monitor_i, start_o, blocked_o;
   wire         redundant_trip_o, breaker_failure_output_o, event_valid_o, event_on_o;
   int          bad_count = 0, compares = 0;

   bfp_core #(.TICK_CYCLES(10)) dut (.ref_clk_i, .rst_n_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
      .hsize_i(3'h2), .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o,
      .phase_over_i, .residual_over_i, .trip_monitor_i, .signal_input_i, .block_i,
      .phase_max_i(16'h1234), .residual_i(16'h0056), .setting_group_i(3'h2), .time_ms_i, .start_o,
      .blocked_o, .redundant_trip_o, .breaker_failure_output_o, .event_valid_o, .event_id_o,
      .event_on_o, .event_stamp_o);
   bfp_partner u_part (.clk_i(ref_clk_i), .fault_i(fault), .trip_en_i(trip_en), .stuck_i(stuck),
      .slow_i(slow), .retrip_i(redundant_trip_o), .current_o(phase_over_i), .trip_mon_o(trip_monitor_i));

   initial forever #50 ref_clk_i = ~ref_clk_i;
   always @(posedge ref_clk_i) time_ms_i <= time_ms_i + 32'h1;
   // Last emitted event and the age of its stamp, judged by the scenarios
   logic [3:0]  ev_last = 4'h0;
   logic [31:0] ev_gap = 32'h0;
   always @(posedge ref_clk_i)
      if (event_valid_o === 1'b1)
      begin
         ev_last <= {event_on_o, event_id_o};
         ev_gap  <= time_ms_i - event_stamp_o;
      end
   // ------
   // Tasks
   // ------
   task automatic complete_run();
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         bad_count++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wait_rdy(inout int n);
      @(posedge ref_clk_i);
      while (hreadyout_o !== 1'b1 && n < 40)
      begin
         @(posedge ref_clk_i);
         n++;
      end
   endtask
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      hsel_i <= 1'b1;
      htrans_i <= 2'h2;
      haddr_i <= a;
      hwrite_i <= wr;
      wait_rdy(n);
      htrans_i <= 2'h0;
      hsel_i <= 1'b0;
      hwdata_i <= wd;
      wait_rdy(n);
      rd = hrdata_o;
      if (n >= 40) bad_count++;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      ahb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask
   // Drive order: fault, trip_en, stuck, slow, signal, block, residual
   task automatic run(input logic [31:0] c, input logic [6:0] d, input logic [2:0] e,
                      input logic [6:0] d2, input logic [2:0] e2);
      ahb(1'b1, 8'h00, c);
      {fault, trip_en, stuck, slow, signal_input_i, block_i, residual_over_i} <= d;
      // Long settle covers a slow primary trip plus the failure delay
      repeat (150) @(posedge ref_clk_i);
      chk({29'h0, blocked_o, breaker_failure_output_o, redundant_trip_o}, {29'h0, e});
      {fault, trip_en, stuck, slow, signal_input_i, block_i, residual_over_i} <= d2;
      repeat (40) @(posedge ref_clk_i);
      chk({29'h0, blocked_o, breaker_failure_output_o, redundant_trip_o}, {29'h0, e2});
      {fault, trip_en, stuck, slow, signal_input_i, block_i, residual_over_i} <= 7'h00;
      repeat (40) @(posedge ref_clk_i);
   endtask
   task automatic test_regs();
      rchk(8'h00, 32'h70);
      rchk(8'h04, 32'h14);
      rchk(8'h08, 32'h28);
      rchk(8'h0C, 32'hFFFF);
      rchk(8'h3C, 32'h0);
      chk({31'h0, hresp_o}, 32'h0);
      ahb(1'b1, 8'h04, 32'h2);
      ahb(1'b1, 8'h08, 32'h4);
      rchk(8'h08, 32'h4);
      $display("test_regs done");
   endtask
   task automatic test_modes();
      run(32'h70, 7'h50, 3'h3, 7'h00, 3'h0);
      rchk(8'h14, 32'h1);
      rchk(8'h18, 32'h1);
      ahb(1'b1, 8'h14, 32'h0);
      rchk(8'h14, 32'h0);
      run(32'h71, 7'h50, 3'h0, 7'h00, 3'h0);
      run(32'h71, 7'h78, 3'h3, 7'h50, 3'h0);
      run(32'h72, 7'h60, 3'h3, 7'h00, 3'h0);
      $display("test_modes done");
   endtask
   task automatic test_misc();
      run(32'h60, 7'h01, 3'h2, 7'h00, 3'h0);
      run(32'h63, 7'h04, 3'h2, 7'h00, 3'h0);
      run(32'h70, 7'h52, 3'h4, 7'h00, 3'h0);
      rchk(8'h24, 32'hC00);
      rchk(8'h30, 32'h12340056);
      rchk(8'h2C, 32'h27);
      rchk(8'h34, 32'h2);
      rchk(8'h38, 32'h4);
      rchk(8'h1C, 32'h6);
      rchk(8'h20, 32'h1);
      chk({28'h0, ev_last}, 32'h3);
      chk(ev_gap, 32'h1);
      $display("test_misc done");
   endtask
   // ------
   // Sequence
   // ------
   initial
   begin
      repeat (6) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      @(posedge ref_clk_i);
      test_regs();
      test_modes();
      test_misc();
      complete_run();
   end
   initial
   begin
      repeat (6000) @(posedge ref_clk_i);
      bad_count++;
      complete_run();
   end
endmodule // tb
